// File: rtl/afdcc_ctrl.sv
// Host controller for a chain of strobe-driven FIFOs sharing write/read strobes.
// Assumes all FIFO flags are synchronous to i_mclk; chain pins are wired
// on the board between devices and not connected here.
`default_nettype none
// Notes on behaviour
// - Board wires chain out to next in
// - First device first-load low, others high
// - Array full when all full flags low
// - Array empty when all empty flags low
// - Release read and load select with reset
// - Settle load select before write strobe
module afdcc_ctrl (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // User commands
  input wire logic i_cfg_chained,
  input wire logic i_init_req,
  input wire logic i_init_prog,
  input wire logic i_prog_dir,
  input wire logic [afdcc_pkg::DATA_W-1:0] i_near_full_cfg,
  input wire logic [afdcc_pkg::DATA_W-1:0] i_near_empty_cfg,
  input wire logic i_wr_req,
  input wire logic [afdcc_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_rd_req,
  input wire logic i_replay_req,
  // User answers
  output logic o_busy,
  output logic o_done,
  output logic o_rd_valid,
  output logic [afdcc_pkg::DATA_W-1:0] o_rd_data,
  output logic o_wr_refused,
  output logic o_rd_refused,
  output logic o_array_full,
  output logic o_array_empty,
  // FIFO pins, shared across the chain; flag bit 0 is the first-load device
  output logic o_init_pulse_n,
  output logic o_wr_strobe_n,
  output logic o_rd_strobe_n,
  output logic o_load_dir_n,
  output logic o_replay_n,
  output logic [afdcc_pkg::DATA_W-1:0] o_fifo_d,
  input wire logic [afdcc_pkg::DATA_W-1:0] i_fifo_q,
  input wire logic [afdcc_pkg::NDEV-1:0] i_full_flag_n,
  input wire logic [afdcc_pkg::NDEV-1:0] i_empty_flag_n
);
  typedef struct packed {
    afdcc_pkg::afdcc_state_t st;
    afdcc_pkg::afdcc_op_t op;
    logic [afdcc_pkg::CNT_W-1:0] cnt;
    logic prog;
    logic [1:0] loads;
    logic init_n;
    logic wr_n;
    logic rd_n;
    logic dir_n;
    logic replay_n;
    logic [afdcc_pkg::DATA_W-1:0] d;
    logic [afdcc_pkg::DATA_W-1:0] rdata;
    logic busy;
    logic done;
    logic rvalid;
    logic wref;
    logic rref;
  } afdcc_ctl_t;
  afdcc_ctl_t s_q;
  afdcc_ctl_t s_d;
  logic arr_full;
  logic arr_empty;
  logic wr_ok;
  logic rd_ok;
  // Array-level flags from all devices
  afdcc_flag_mon u_mon (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_full_flag_n(i_full_flag_n),
    .i_empty_flag_n(i_empty_flag_n),
    .o_full(arr_full),
    .o_empty(arr_empty)
  );
  // Gates use raw flags so a strobe never starts on a stale registered view
  always_comb begin
    wr_ok = (i_full_flag_n != afdcc_pkg::ALL_LOW);
    rd_ok = (i_empty_flag_n != afdcc_pkg::ALL_LOW);
  end
  // Sequencer: one operation at a time, strobes timed by counters
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rvalid = 1'b0;
    s_d.wref = 1'b0;
    s_d.rref = 1'b0;
    unique case (s_q.st)
      afdcc_pkg::ST_IDLE: begin
        if (i_init_req) begin
          // Chain token setup is the devices' job on reset pulse
          s_d.st = afdcc_pkg::ST_RST;
          s_d.prog = i_init_prog;
          s_d.loads = 2'h0;
          s_d.init_n = 1'b0;
          s_d.cnt = afdcc_pkg::CYC_RST_TO_RD;
          s_d.busy = 1'b1;
        end else if (i_replay_req) begin
          if (i_cfg_chained) begin
            s_d.rref = 1'b1;
          end else begin
            s_d.st = afdcc_pkg::ST_STRB;
            s_d.op = afdcc_pkg::OP_REPLAY;
            s_d.replay_n = 1'b0;
            s_d.cnt = afdcc_pkg::CYC_STROBE_PW;
            s_d.busy = 1'b1;
          end
        end else if (i_wr_req) begin
          if (wr_ok) begin
            s_d.st = afdcc_pkg::ST_SETUP;
            s_d.op = afdcc_pkg::OP_WRITE;
            s_d.d = i_wr_data;
            s_d.cnt = afdcc_pkg::CYC_SETUP;
            s_d.busy = 1'b1;
          end else begin
            s_d.wref = 1'b1;
          end
        end else if (i_rd_req) begin
          if (rd_ok) begin
            s_d.st = afdcc_pkg::ST_STRB;
            s_d.op = afdcc_pkg::OP_READ;
            s_d.rd_n = 1'b0;
            s_d.cnt = afdcc_pkg::CYC_STROBE_PW;
            s_d.busy = 1'b1;
          end else begin
            s_d.rref = 1'b1;
          end
        end
      end
      afdcc_pkg::ST_RST: begin
        // Reset low; with programming, read strobe follows after a delay
        if (s_q.cnt != afdcc_pkg::CNT_ONE) begin
          s_d.cnt = s_q.cnt - afdcc_pkg::CNT_ONE;
        end else if (s_q.prog) begin
          s_d.rd_n = 1'b0;
          s_d.dir_n = i_prog_dir;
          s_d.st = afdcc_pkg::ST_LOAD;
          s_d.cnt = afdcc_pkg::CYC_RD_TO_LOAD;
        end else begin
          s_d.init_n = 1'b1;
          s_d.st = afdcc_pkg::ST_RCV;
          s_d.cnt = afdcc_pkg::CYC_RST_RECOV;
        end
      end
      afdcc_pkg::ST_LOAD: begin
        // Two write pulses: near-full register, then near-empty
        if (s_q.cnt != afdcc_pkg::CNT_ONE) begin
          s_d.cnt = s_q.cnt - afdcc_pkg::CNT_ONE;
        end else if (s_q.loads == 2'h2) begin
          s_d.init_n = 1'b1;
          s_d.rd_n = 1'b1;
          s_d.dir_n = 1'b1;
          s_d.st = afdcc_pkg::ST_RCV;
          s_d.cnt = afdcc_pkg::CYC_RST_RECOV;
        end else if (s_q.wr_n) begin
          s_d.d = (s_q.loads == 2'h0) ? i_near_full_cfg : i_near_empty_cfg;
          s_d.wr_n = 1'b0;
          s_d.cnt = afdcc_pkg::CYC_STROBE_PW;
        end else begin
          s_d.wr_n = 1'b1;
          s_d.loads = s_q.loads + 2'h1;
          s_d.cnt = afdcc_pkg::CYC_STROBE_REC;
        end
      end
      afdcc_pkg::ST_SETUP: begin
        // Data settles before the strobe falls
        if (s_q.cnt != afdcc_pkg::CNT_ONE) begin
          s_d.cnt = s_q.cnt - afdcc_pkg::CNT_ONE;
        end else begin
          s_d.wr_n = 1'b0;
          s_d.st = afdcc_pkg::ST_STRB;
          s_d.cnt = afdcc_pkg::CYC_STROBE_PW;
        end
      end
      afdcc_pkg::ST_STRB: begin
        if (s_q.cnt != afdcc_pkg::CNT_ONE) begin
          s_d.cnt = s_q.cnt - afdcc_pkg::CNT_ONE;
        end else begin
          if (s_q.op == afdcc_pkg::OP_READ) begin
            s_d.rdata = i_fifo_q; // Data valid by end of pulse
            s_d.rvalid = 1'b1;
          end
          s_d.wr_n = 1'b1;
          s_d.rd_n = 1'b1;
          s_d.replay_n = 1'b1;
          s_d.st = afdcc_pkg::ST_REC;
          s_d.cnt = afdcc_pkg::CYC_STROBE_REC;
        end
      end
      afdcc_pkg::ST_RCV, afdcc_pkg::ST_REC: begin
        if (s_q.cnt != afdcc_pkg::CNT_ONE) begin
          s_d.cnt = s_q.cnt - afdcc_pkg::CNT_ONE;
        end else begin
          s_d.st = afdcc_pkg::ST_IDLE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end
      end
    endcase
  end
  // State register; reset holds every control pin idle high and the data bus at zero
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s_q <= '{st: afdcc_pkg::ST_IDLE, op: afdcc_pkg::OP_WRITE, cnt: afdcc_pkg::CNT_ZERO,
               prog: 1'b0, loads: 2'h0, init_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
               dir_n: 1'b1, replay_n: 1'b1, d: afdcc_pkg::DATA_ZERO,
               rdata: afdcc_pkg::DATA_ZERO, busy: 1'b0, done: 1'b0, rvalid: 1'b0,
               wref: 1'b0, rref: 1'b0};
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end
  // Outputs straight from flops
  assign o_busy = s_q.busy;
  assign o_done = s_q.done;
  assign o_rd_valid = s_q.rvalid;
  assign o_rd_data = s_q.rdata;
  assign o_wr_refused = s_q.wref;
  assign o_rd_refused = s_q.rref;
  assign o_array_full = arr_full;
  assign o_array_empty = arr_empty;
  assign o_init_pulse_n = s_q.init_n;
  assign o_wr_strobe_n = s_q.wr_n;
  assign o_rd_strobe_n = s_q.rd_n;
  assign o_load_dir_n = s_q.dir_n;
  assign o_replay_n = s_q.replay_n;
  assign o_fifo_d = s_q.d;
endmodule : afdcc_ctrl
`default_nettype wire

// File: rtl/afdcc_pkg.sv
// Package for the cascaded strobe FIFO controller: pin timing, states, widths.
// Assumes a 50 MHz system clock and one chain of strobe-driven FIFOs.
`default_nettype none
package afdcc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // Pin timing figures, ns
  localparam int unsigned T_RST_PULSE_NS = 35;
  localparam int unsigned T_RST_RECOV_NS = 10;
  localparam int unsigned T_RST_TO_RD_NS = 35;
  localparam int unsigned T_STROBE_PW_NS = 35;
  localparam int unsigned T_STROBE_REC_NS = 10;
  localparam int unsigned T_RD_TO_LOAD_NS = 10;
  localparam int unsigned T_SETUP_NS = 18;
  // Least times round up to whole cycles, at least one
  function automatic int unsigned afdcc_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : afdcc_cyc
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CYC_RST_PULSE = CNT_W'(afdcc_cyc(T_RST_PULSE_NS));
  localparam logic [CNT_W-1:0] CYC_RST_RECOV = CNT_W'(afdcc_cyc(T_RST_RECOV_NS));
  localparam logic [CNT_W-1:0] CYC_RST_TO_RD = CNT_W'(afdcc_cyc(T_RST_TO_RD_NS));
  localparam logic [CNT_W-1:0] CYC_STROBE_PW = CNT_W'(afdcc_cyc(T_STROBE_PW_NS));
  localparam logic [CNT_W-1:0] CYC_STROBE_REC = CNT_W'(afdcc_cyc(T_STROBE_REC_NS));
  localparam logic [CNT_W-1:0] CYC_RD_TO_LOAD = CNT_W'(afdcc_cyc(T_RD_TO_LOAD_NS));
  localparam logic [CNT_W-1:0] CYC_SETUP = CNT_W'(afdcc_cyc(T_SETUP_NS));
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  // Data and chain widths
  localparam int unsigned DATA_W = 9;
  localparam int unsigned NDEV = 3;
  localparam logic [DATA_W-1:0] DATA_ZERO = 9'h000;
  localparam logic [NDEV-1:0] ALL_LOW = 3'h0;
  localparam logic [NDEV-1:0] ALL_HIGH = 3'h7;
  localparam logic [NDEV-1:0] FIRST_ONLY_LOW = 3'h6;
  // Controller states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RST = 7'h02,
    ST_LOAD = 7'h04,
    ST_RCV = 7'h08,
    ST_STRB = 7'h10,
    ST_REC = 7'h20,
    ST_SETUP = 7'h40
  } afdcc_state_t;
  // Operation kinds
  typedef enum logic [2:0] {
    OP_WRITE = 3'h1,
    OP_READ = 3'h2,
    OP_REPLAY = 3'h4
  } afdcc_op_t;
endpackage : afdcc_pkg
`default_nettype wire

// File: rtl/afdcc_flag_mon.sv
// Merges per-device full and empty flags of the chain into array status.
// Assumes flags already synchronous to i_mclk; outputs registered.
`default_nettype none
module afdcc_flag_mon (
  // Clock and control
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Device flags, active low
  input wire logic [afdcc_pkg::NDEV-1:0] i_full_flag_n,
  input wire logic [afdcc_pkg::NDEV-1:0] i_empty_flag_n,
  // Array status
  output logic o_full,
  output logic o_empty
);
  typedef struct packed {
    logic full;
    logic empty;
  } afdcc_mon_t;
  afdcc_mon_t s_q;
  afdcc_mon_t s_d;
  // Whole array counts only when every device agrees
  always_comb begin
    s_d = s_q;
    s_d.full = (i_full_flag_n == afdcc_pkg::ALL_LOW);
    s_d.empty = (i_empty_flag_n == afdcc_pkg::ALL_LOW);
  end
  // Reset reports empty, never full
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s_q <= '{full: 1'b0, empty: 1'b1};
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end
  assign o_full = s_q.full;
  assign o_empty = s_q.empty;
endmodule : afdcc_flag_mon
`default_nettype wire

// File: verif/afdcc_ctrl_assertions.sv
// Checker for the cascaded FIFO controller: pin sequencing and array status.
// Bound to afdcc_ctrl; sees its ports only, one clock domain.
`default_nettype none
module afdcc_ctrl_assertions (
  // Clock and requests
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_cfg_chained,
  input wire logic i_init_req,
  input wire logic i_wr_req,
  input wire logic i_rd_req,
  input wire logic i_replay_req,
  input wire logic [afdcc_pkg::NDEV-1:0] i_full_flag_n,
  input wire logic [afdcc_pkg::NDEV-1:0] i_empty_flag_n,
  // Answers and pins
  input wire logic o_done,
  input wire logic o_busy,
  input wire logic o_rd_valid,
  input wire logic o_wr_refused,
  input wire logic o_rd_refused,
  input wire logic o_array_full,
  input wire logic o_array_empty,
  input wire logic o_init_pulse_n,
  input wire logic o_wr_strobe_n,
  input wire logic o_rd_strobe_n,
  input wire logic o_load_dir_n,
  input wire logic o_replay_n
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // Taken in idle with nothing of higher priority pending
  wire go = !o_busy && i_ce && !i_init_req && !i_replay_req;
  property p_wr_seq;
    go && i_wr_req && i_full_flag_n != afdcc_pkg::ALL_LOW
      |-> ##2 $fell(o_wr_strobe_n) ##2 $rose(o_wr_strobe_n) ##1 o_done;
  endproperty
  a_wr_seq: assert property (p_wr_seq) else $error("write strobe sequence wrong");
  property p_rd_seq;
    go && !i_wr_req && i_rd_req && i_empty_flag_n != afdcc_pkg::ALL_LOW
      |-> ##1 $fell(o_rd_strobe_n) ##2 ($rose(o_rd_strobe_n) && o_rd_valid) ##1 o_done;
  endproperty
  a_rd_seq: assert property (p_rd_seq) else $error("read strobe sequence wrong");
  property p_wr_ref;
    go && i_wr_req && i_full_flag_n == afdcc_pkg::ALL_LOW |=> o_wr_refused && o_wr_strobe_n;
  endproperty
  a_wr_ref: assert property (p_wr_ref) else $error("write to full array not refused");
  property p_rd_ref;
    go && !i_wr_req && i_rd_req && i_empty_flag_n == afdcc_pkg::ALL_LOW
      |=> o_rd_refused && o_rd_strobe_n;
  endproperty
  a_rd_ref: assert property (p_rd_ref) else $error("read of empty array not refused");
  property p_no_replay;
    !o_busy && i_ce && !i_init_req && i_replay_req && i_cfg_chained |=> o_replay_n [*3];
  endproperty
  a_no_replay: assert property (p_no_replay) else $error("replay pulsed in chain mode");
  property p_replay_w;
    $fell(o_replay_n) |=> !o_replay_n ##1 o_replay_n;
  endproperty
  a_replay_w: assert property (p_replay_w) else $error("replay pulse width wrong");
  property p_init_rel;
    $rose(o_init_pulse_n) |-> o_rd_strobe_n && o_load_dir_n && !$past(o_init_pulse_n, 2);
  endproperty
  a_init_rel: assert property (p_init_rel) else $error("init release out of step");
  property p_dir_set;
    $fell(o_wr_strobe_n) && !o_init_pulse_n |-> $stable(o_load_dir_n) && !o_rd_strobe_n;
  endproperty
  a_dir_set: assert property (p_dir_set) else $error("load select moved at strobe");
  property p_full;
    i_ce |=> o_array_full == ($past(i_full_flag_n) == afdcc_pkg::ALL_LOW);
  endproperty
  a_full: assert property (p_full) else $error("array full status wrong");
  property p_empty;
    i_ce |=> o_array_empty == ($past(i_empty_flag_n) == afdcc_pkg::ALL_LOW);
  endproperty
  a_empty: assert property (p_empty) else $error("array empty status wrong");
  // Main scenarios reached
  c_wr: cover property (!o_wr_strobe_n ##2 o_done);
  c_prog: cover property (!o_init_pulse_n && $fell(o_wr_strobe_n));
  c_replay: cover property ($fell(o_replay_n));
endmodule : afdcc_ctrl_assertions
bind afdcc_ctrl afdcc_ctrl_assertions u_chk (.i_mclk, .i_sys_rst, .i_ce, .i_cfg_chained,
  .i_init_req, .i_wr_req, .i_rd_req, .i_replay_req, .i_full_flag_n, .i_empty_flag_n, .o_done,
  .o_busy, .o_rd_valid, .o_wr_refused, .o_rd_refused, .o_array_full, .o_array_empty,
  .o_init_pulse_n, .o_wr_strobe_n, .o_rd_strobe_n, .o_load_dir_n, .o_replay_n);
`default_nettype wire

// File: verif/afdcc_fifo_model.sv
// Behavioural chain of three strobe FIFOs seen as one array.
// Assumes strobes from the controller; DEPTH words a device, no wrap.
`default_nettype none
module afdcc_fifo_model #(
  parameter int DEPTH = 2
) (
  // Strobes, active low
  input wire logic i_init_pulse_n,
  input wire logic i_wr_strobe_n,
  input wire logic i_rd_strobe_n,
  input wire logic i_replay_n,
  // Data and flags
  input wire logic [afdcc_pkg::DATA_W-1:0] i_d,
  output logic [afdcc_pkg::DATA_W-1:0] o_q = 9'h000,
  output logic [afdcc_pkg::NDEV-1:0] o_full_flag_n,
  output logic [afdcc_pkg::NDEV-1:0] o_empty_flag_n
);
  logic [afdcc_pkg::DATA_W-1:0] mem [3*DEPTH];
  logic [afdcc_pkg::DATA_W-1:0] near_full_q = 9'h000;
  logic [afdcc_pkg::DATA_W-1:0] near_empty_q = 9'h000;
  int wp = 0;
  int rp = 0;
  int n_load = 0;
  // Power-up rise of the write strobe from unknown must not count as a write
  logic wr_low = 1'b0;
  always @(negedge i_wr_strobe_n) wr_low = 1'b1;
  // Chain wired in order; reset rewinds all, first device holds both tokens
  always @(negedge i_init_pulse_n) begin
    wp = 0;
    rp = 0;
    n_load = 0;
  end
  // Word latched at strobe rise; write token passes at each device's end
  always @(posedge i_wr_strobe_n) begin
    if (wr_low && !i_init_pulse_n) begin
      if (n_load == 0) near_full_q = i_d;
      else near_empty_q = i_d;
      n_load++;
    end else if (wr_low && wp < 3 * DEPTH) begin
      mem[wp] = i_d;
      wp++;
    end
    wr_low = 1'b0;
  end
  // Read token chases the write token, never past it
  always @(negedge i_rd_strobe_n) begin
    if (i_init_pulse_n && rp < wp) begin
      o_q = mem[rp];
      rp++;
    end
  end
  // Released bus shows the inverse so a stale word cannot pass
  always @(posedge i_rd_strobe_n) #5 o_q = ~o_q;
  // Replay rewinds reads only
  always @(negedge i_replay_n) rp = 0;
  // Per-device flags from the shared pointers
  always @* begin
    for (int k = 0; k < 3; k++) begin
      o_full_flag_n[k] = !(wp >= (k + 1) * DEPTH);
      // Low means empty: high only while the device holds unread words
      o_empty_flag_n[k] = (rp < wp && rp < (k + 1) * DEPTH && wp > k * DEPTH);
    end
  end
endmodule : afdcc_fifo_model
`default_nettype wire

// File: verif/tb_top.sv
// Testbench: controller driving the behavioural FIFO chain.
// Assumes package, controller, checker and chain model compiled before.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic chained = 1'b0;
  logic init_req = 1'b0;
  logic init_prog = 1'b0;
  logic wr_req = 1'b0;
  logic rd_req = 1'b0;
  logic replay_req = 1'b0;
  logic [8:0] wr_data = 9'h000;
  logic busy, done, rd_valid, wr_ref, rd_ref, a_full, a_empty, refd;
  logic init_n, wr_n, rd_n, dir_n, replay_n;
  logic [8:0] rd_data, fifo_d, fifo_q, got;
  logic [2:0] full_n, empty_n;
  int fails = 0;
  int n_compared = 0;
  always #10 mclk = ~mclk;
  afdcc_ctrl u_dut (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_ce(1'b1), .i_cfg_chained(chained),
    .i_init_req(init_req), .i_init_prog(init_prog), .i_prog_dir(1'b0),
    .i_near_full_cfg(9'h0AB), .i_near_empty_cfg(9'h155), .i_wr_req(wr_req),
    .i_wr_data(wr_data), .i_rd_req(rd_req), .i_replay_req(replay_req), .o_busy(busy),
    .o_done(done), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_wr_refused(wr_ref),
    .o_rd_refused(rd_ref), .o_array_full(a_full), .o_array_empty(a_empty),
    .o_init_pulse_n(init_n), .o_wr_strobe_n(wr_n), .o_rd_strobe_n(rd_n),
    .o_load_dir_n(dir_n), .o_replay_n(replay_n), .o_fifo_d(fifo_d), .i_fifo_q(fifo_q),
    .i_full_flag_n(full_n), .i_empty_flag_n(empty_n));
  afdcc_fifo_model u_model (.i_init_pulse_n(init_n), .i_wr_strobe_n(wr_n),
    .i_rd_strobe_n(rd_n), .i_replay_n(replay_n), .i_d(fifo_d), .o_q(fifo_q),
    .o_full_flag_n(full_n), .o_empty_flag_n(empty_n));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // One operation: 0 init, 1 write, 2 read, 3 replay, 4 init with loading
  task automatic op(input int kind, input logic [8:0] d);
    int i;
    @(posedge mclk);
    init_req <= (kind == 0 || kind == 4);
    init_prog <= (kind == 4);
    wr_req <= (kind == 1);
    rd_req <= (kind == 2);
    replay_req <= (kind == 3);
    wr_data <= d;
    @(posedge mclk);
    {init_req, init_prog, wr_req, rd_req, replay_req} <= 5'h00;
    refd = 1'b0;
    got = 'x;
    for (i = 0; i < 20; i++) begin
      @(negedge mclk);
      if (rd_valid) got = rd_data;
      refd = refd | wr_ref | rd_ref;
      if (done || refd) break;
    end
    if (i == 20) begin
      fails++;
      summarize();
    end
  endtask : op
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    check({8'h00, a_empty}, 9'h001);
    op(4, 9'h000);
    check(u_model.near_full_q, 9'h0AB);
    check(u_model.near_empty_q, 9'h155);
    check({8'h00, a_empty}, 9'h001);
    op(2, 9'h000);
    check({8'h00, refd}, 9'h001);
    for (int k = 0; k < 6; k++) op(1, 9'(9'h0A0 + k));
    check({8'h00, a_full}, 9'h001);
    op(1, 9'h1FF);
    check({8'h00, refd}, 9'h001);
    for (int k = 0; k < 2; k++) begin
      op(2, 9'h000);
      check(got, 9'(9'h0A0 + k));
    end
    op(3, 9'h000);
    for (int k = 0; k < 6; k++) begin
      op(2, 9'h000);
      check(got, 9'(9'h0A0 + k));
    end
    check({8'h00, a_empty}, 9'h001);
    op(2, 9'h000);
    check({8'h00, refd}, 9'h001);
    @(posedge mclk);
    chained <= 1'b1;
    op(3, 9'h000);
    check({8'h00, refd}, 9'h001);
    op(0, 9'h000);
    check({8'h00, a_full}, 9'h000);
    op(1, 9'h0C3);
    check({8'h00, refd}, 9'h000);
    op(2, 9'h000);
    check(got, 9'h0C3);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
